//--- mdu_pkg.sv
// Constants, command and working types shared by the multiply/divide unit.
// What this block does
// - Signed 32/16 division gives a 32-bit quotient and 16-bit remainder in 33 cycles.
// - Signed 16/16 division gives a 16-bit quotient and 16-bit remainder in 17 cycles.
// - Signed 16x16 multiplication gives a 32-bit product in 16 cycles.
// - Unsigned 32/16 division gives a 32-bit quotient and 16-bit remainder in 32 cycles.
// - Unsigned 16/16 division gives a 16-bit quotient and 16-bit remainder in 16 cycles.
// - Unsigned 16x16 multiplication gives a 32-bit product in 16 cycles.
// - Normalizing a 32-bit value takes the number of shifts plus one cycle, at most 32.
// - A 32-bit left/right arithmetic/logical shift takes the count plus one cycle, at most 32.
// - Operand and result bytes share addresses, writes hit operands, reads return results, both reset to zero.
package mdu_pkg;

	// Byte slots shared by operands and results.
	localparam int MDU_BYTES = 6;
	localparam logic [7:0] MDU_BYTE_RESET = 8'h00;
	localparam logic [2:0] MDU_IDX_REM_LO = 3'h4;

	// Iteration counts of the arithmetic operations.
	localparam logic [5:0] MDU_CYC_DIV32 = 6'h20;
	localparam logic [5:0] MDU_CYC_DIV16 = 6'h10;
	localparam logic [5:0] MDU_CYC_MUL16 = 6'h10;
	localparam logic [4:0] MDU_MAX_SHIFT = 5'h1F;

	// Operation selector.
	typedef enum logic [2:0] {
		MDU_OP_DIV32,
		MDU_OP_DIV16,
		MDU_OP_MUL16,
		MDU_OP_NORM,
		MDU_OP_SHIFT
	} mdu_op_t;

	// Command presented with the start strobe.
	typedef struct packed {
		mdu_op_t op;
		logic is_signed;
		logic [4:0] shift_cnt;
		logic shift_right;
		logic shift_arith;
	} mdu_cmd_t;

	// Working registers: partial remainder or product high half, and quotient/shift value.
	typedef struct packed {
		logic [16:0] rem;
		logic [31:0] quo;
	} mdu_work_t;

endpackage

//--- mdu_iter_step.sv
// One iteration of restoring division or shift-and-add multiplication.
`timescale 1ns/100ps
module mdu_iter_step
	import mdu_pkg::*;
(
	// Current working state.
	input mdu_work_t work_in,
	input logic [15:0] operand,
	input logic is_mul,
	// Next working state.
	output mdu_work_t work_out
);

	logic [16:0] rem_shift;
	logic [16:0] rem_diff;
	logic [16:0] mul_sum;

	// Both step kinds are computed each cycle; the mode picks one.
	always_comb begin
		rem_shift = {work_in.rem[15:0], work_in.quo[31]};
		rem_diff = rem_shift - {1'b0, operand};
		mul_sum = {1'b0, work_in.rem[15:0]} + (work_in.quo[0] ? {1'b0, operand} : 17'h00000);
		if (is_mul) begin
			work_out.rem = {1'b0, mul_sum[16:1]};
			work_out.quo = {16'h0000, mul_sum[0], work_in.quo[15:1]};
		end else if (rem_diff[16] == 1'b0) begin
			work_out.rem = rem_diff;
			work_out.quo = {work_in.quo[30:0], 1'b1};
		end else begin
			work_out.rem = rem_shift;
			work_out.quo = {work_in.quo[30:0], 1'b0};
		end
	end

endmodule // mdu_iter_step

//--- mdu_top.sv
// Multiply/divide unit with byte-wide operand and result access.
`timescale 1ns/100ps
module mdu_top
	import mdu_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Byte access from the core.
	input wire logic [2:0] ADDR,
	input wire logic WR_EN,
	input wire logic [7:0] WDATA,
	output logic [7:0] RDATA,
	// Command.
	input wire logic START,
	input wire mdu_cmd_t CMD,
	// Status.
	output logic BUSY,
	output logic DONE
);

	typedef enum logic [1:0] {ST_IDLE, ST_PREP, ST_RUN} mdu_state_t;

	mdu_state_t state_reg, state_next;
	mdu_cmd_t cmd_reg, cmd_next;
	mdu_work_t work_reg, work_next, work_step;
	logic [47:0] opnd_reg, opnd_next;
	logic [47:0] res_reg, res_next;
	logic [15:0] divisor_reg, divisor_next;
	logic [5:0] cnt_reg, cnt_next;
	logic [4:0] nshift_reg, nshift_next;
	logic neg_q_reg, neg_q_next;
	logic neg_r_reg, neg_r_next;
	logic done_reg, done_next;
	logic [7:0] rdata_reg, rdata_next;

	logic [31:0] dvd32;
	logic [15:0] dvd16;
	logic [15:0] dvs16;
	logic [31:0] q_mag;
	logic [15:0] r_mag;
	logic [31:0] q_fix;
	logic [15:0] r_fix;

	// Operand fields as the core left them.
	assign dvd32 = opnd_reg[31:0];
	assign dvd16 = opnd_reg[15:0];
	assign dvs16 = opnd_reg[47:32];

	// Shared iteration datapath for division and multiplication.
	mdu_iter_step u_step (
		.work_in(work_reg),
		.operand(divisor_reg),
		.is_mul(cmd_reg.op == MDU_OP_MUL16),
		.work_out(work_step)
	);

	// Sign restore of magnitude results for signed operations.
	always_comb begin
		if (cmd_reg.op == MDU_OP_MUL16) begin
			q_mag = {work_step.rem[15:0], work_step.quo[15:0]};
		end else if (cmd_reg.op == MDU_OP_DIV16) begin
			q_mag = {16'h0000, work_step.quo[15:0]};
		end else begin
			q_mag = work_step.quo;
		end
		r_mag = work_step.rem[15:0];
		q_fix = neg_q_reg ? (32'h00000000 - q_mag) : q_mag;
		r_fix = neg_r_reg ? (16'h0000 - r_mag) : r_mag;
		if (cmd_reg.op == MDU_OP_DIV16) begin
			q_fix = {16'h0000, q_fix[15:0]};
		end
	end

	// Sequencer, operand capture and result update.
	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		work_next = work_reg;
		opnd_next = opnd_reg;
		res_next = res_reg;
		divisor_next = divisor_reg;
		cnt_next = cnt_reg;
		nshift_next = nshift_reg;
		neg_q_next = neg_q_reg;
		neg_r_next = neg_r_reg;
		done_next = done_reg;
		if (WR_EN && (ADDR < 3'(MDU_BYTES))) begin
			opnd_next[ADDR * 8 +: 8] = WDATA;
		end
		unique case (state_reg)
			ST_IDLE: begin
				if (START) begin
					cmd_next = CMD;
					done_next = 1'b0;
					nshift_next = 5'h00;
					neg_q_next = 1'b0;
					neg_r_next = 1'b0;
					divisor_next = dvs16;
					work_next.rem = 17'h00000;
					work_next.quo = dvd32;
					state_next = ST_RUN;
					unique case (CMD.op)
						MDU_OP_DIV32: begin
							cnt_next = MDU_CYC_DIV32;
							if (CMD.is_signed) begin
								neg_q_next = dvd32[31] ^ dvs16[15];
								neg_r_next = dvd32[31];
								work_next.quo = dvd32[31] ? (32'h00000000 - dvd32) : dvd32;
								divisor_next = dvs16[15] ? (16'h0000 - dvs16) : dvs16;
								state_next = ST_PREP;
							end
						end
						MDU_OP_DIV16: begin
							cnt_next = MDU_CYC_DIV16;
							work_next.quo = {dvd16, 16'h0000};
							if (CMD.is_signed) begin
								neg_q_next = dvd16[15] ^ dvs16[15];
								neg_r_next = dvd16[15];
								work_next.quo = {(dvd16[15] ? (16'h0000 - dvd16) : dvd16), 16'h0000};
								divisor_next = dvs16[15] ? (16'h0000 - dvs16) : dvs16;
								state_next = ST_PREP;
							end
						end
						MDU_OP_MUL16: begin
							cnt_next = MDU_CYC_MUL16;
							work_next.quo = {16'h0000, dvd16};
							if (CMD.is_signed) begin
								// magnitudes, sign fixed on last step
								neg_q_next = dvd16[15] ^ dvs16[15];
								work_next.quo = {16'h0000, (dvd16[15] ? (16'h0000 - dvd16) : dvd16)};
								divisor_next = dvs16[15] ? (16'h0000 - dvs16) : dvs16;
							end
						end
						MDU_OP_NORM: begin
							cnt_next = 6'h00;
						end
						MDU_OP_SHIFT: begin
							cnt_next = {1'b0, CMD.shift_cnt};
						end
						default: begin
							// An undefined operation code is refused, so the unit never runs on stale counts.
							cmd_next = cmd_reg;
							done_next = done_reg;
							state_next = ST_IDLE;
						end
					endcase
				end
			end
			ST_PREP: begin
				state_next = ST_RUN;
			end
			ST_RUN: begin
				unique case (cmd_reg.op)
					MDU_OP_NORM: begin
						// one shift per cycle, final cycle reports
						if (!work_reg.quo[31] && (work_reg.quo != 32'h00000000)
							&& (nshift_reg < MDU_MAX_SHIFT)) begin
							work_next.quo = {work_reg.quo[30:0], 1'b0};
							nshift_next = nshift_reg + 5'h01;
						end else begin
							res_next = {8'h00, 3'h0, nshift_reg, work_reg.quo};
							done_next = 1'b1;
							state_next = ST_IDLE;
						end
					end
					MDU_OP_SHIFT: begin
						// count shifts then one closing cycle
						if (cnt_reg != 6'h00) begin
							cnt_next = cnt_reg - 6'h01;
							if (cmd_reg.shift_right) begin
								work_next.quo = {cmd_reg.shift_arith & work_reg.quo[31],
									work_reg.quo[31:1]};
							end else begin
								work_next.quo = {work_reg.quo[30:0], 1'b0};
							end
						end else begin
							res_next = {16'h0000, work_reg.quo};
							done_next = 1'b1;
							state_next = ST_IDLE;
						end
					end
					default: begin
						work_next = work_step;
						cnt_next = cnt_reg - 6'h01;
						if (cnt_reg == 6'h01) begin
							done_next = 1'b1;
							state_next = ST_IDLE;
							if (cmd_reg.op == MDU_OP_MUL16) begin
								res_next = {16'h0000, q_fix};
							end else begin
								res_next = {r_fix, q_fix};
							end
						end
					end
				endcase
			end
		endcase
	end

	// reads return result bytes, registered one cycle
	always_comb begin
		rdata_next = (ADDR < 3'(MDU_BYTES)) ? res_reg[ADDR * 8 +: 8] : MDU_BYTE_RESET;
	end

	// State registers; all clear to zero under reset.
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			state_reg <= ST_IDLE;
			cmd_reg <= '0;
			work_reg <= '0;
			opnd_reg <= '0;
			res_reg <= '0;
			divisor_reg <= 16'h0000;
			cnt_reg <= 6'h00;
			nshift_reg <= 5'h00;
			neg_q_reg <= 1'b0;
			neg_r_reg <= 1'b0;
			done_reg <= 1'b0;
			rdata_reg <= MDU_BYTE_RESET;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			work_reg <= work_next;
			opnd_reg <= opnd_next;
			res_reg <= res_next;
			divisor_reg <= divisor_next;
			cnt_reg <= cnt_next;
			nshift_reg <= nshift_next;
			neg_q_reg <= neg_q_next;
			neg_r_reg <= neg_r_next;
			done_reg <= done_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs; busy is a plain decode of the state register.
	assign RDATA = rdata_reg;
	assign DONE = done_reg;
	assign BUSY = (state_reg != ST_IDLE);

endmodule // mdu_top

//--- mdu_top_monitor.sv
// Checker of cycle counts, status and read-back of the multiply/divide unit.
`timescale 1ns/100ps
module mdu_top_monitor
	import mdu_pkg::*;
(
	// Clock and reset.
	input wire logic CLK,
	input wire logic RST_N,
	// Watched ports.
	input wire logic [2:0] ADDR,
	input wire logic [7:0] RDATA,
	input wire logic START,
	input wire mdu_cmd_t CMD,
	input wire logic BUSY,
	input wire logic DONE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic [5:0] n_reg;
	mdu_cmd_t cm_reg;
	// Busy cycles since the accepted start; a refused start must not restart the count.
	always_ff @(posedge CLK) begin
		if (!RST_N || (START && !BUSY)) begin
			n_reg <= 6'h00;
			cm_reg <= CMD;
		end else if (BUSY) begin
			n_reg <= n_reg + 6'h01;
		end
	end
	property p_div32;
		$rose(DONE) && cm_reg.op == MDU_OP_DIV32 |-> n_reg == (cm_reg.is_signed ? 6'h21 : 6'h20);
	endproperty
	a_div32: assert property (p_div32) else $error("long divide cycles");
	property p_div16;
		$rose(DONE) && cm_reg.op == MDU_OP_DIV16 |-> n_reg == (cm_reg.is_signed ? 6'h11 : 6'h10);
	endproperty
	a_div16: assert property (p_div16) else $error("short divide cycles");
	property p_mul;
		START && !BUSY && CMD.op == MDU_OP_MUL16 |-> ##16 BUSY ##1 (DONE && !BUSY);
	endproperty
	a_mul: assert property (p_mul) else $error("multiply cycles");
	property p_norm;
		$rose(DONE) && cm_reg.op == MDU_OP_NORM |-> n_reg inside {[6'h01:6'h20]};
	endproperty
	a_norm: assert property (p_norm) else $error("normalize cycles");
	property p_shift;
		$rose(DONE) && cm_reg.op == MDU_OP_SHIFT |-> n_reg == {1'b0, cm_reg.shift_cnt} + 6'h01;
	endproperty
	a_shift: assert property (p_shift) else $error("shift cycles");
	property p_hole;
		ADDR > 3'h5 |=> RDATA == MDU_BYTE_RESET;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read not zero");
	property p_rst;
		disable iff (1'b0) !RST_N |=> !BUSY && !DONE && RDATA == 8'h00;
	endproperty
	a_rst: assert property (p_rst) else $error("reset state wrong");
	property p_done;
		$rose(DONE) |-> $past(BUSY) && !BUSY;
	endproperty
	a_done: assert property (p_done) else $error("done without busy");
endmodule // mdu_top_monitor

bind mdu_top mdu_top_monitor u_mdu_top_monitor (.CLK, .RST_N, .ADDR, .RDATA, .START, .CMD,
	.BUSY, .DONE);

//--- mdu_core_model.sv
// Model of the core that writes operands, starts operations and reads results.
`timescale 1ns/100ps
module mdu_core_model
	import mdu_pkg::*;
(
	// Clock and answers from the unit.
	input wire logic CLK,
	input wire logic [7:0] RDATA,
	input wire logic DONE,
	// Requests to the unit.
	output logic [2:0] ADDR,
	output logic WR_EN,
	output logic [7:0] WDATA,
	output logic START,
	output mdu_cmd_t CMD
);
	// Idle request lines at time zero.
	initial begin
		ADDR = 3'h0;
		WR_EN = 1'b0;
		WDATA = 8'h00;
		START = 1'b0;
		CMD = '0;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge CLK);
		ADDR = a;
		WDATA = d;
		WR_EN = 1'b1;
	endtask
	task automatic pulse(input mdu_cmd_t c);
		@(negedge CLK);
		WR_EN = 1'b0;
		WDATA = ~WDATA; // Stale data is not left looking valid.
		START = 1'b1;
		CMD = c;
		@(negedge CLK);
		START = 1'b0;
	endtask
	task automatic go(input mdu_cmd_t c, output int n);
		pulse(c);
		n = 0;
		while (DONE !== 1'b1 && n < 40) begin
			@(negedge CLK);
			n++;
		end
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge CLK);
		WR_EN = 1'b0;
		ADDR = a;
		@(negedge CLK);
		d = RDATA;
	endtask
endmodule // mdu_core_model

//--- mdu_top_bench.sv
// Self-checking bench of the multiply/divide unit.
`timescale 1ns/100ps
module mdu_top_bench
	import mdu_pkg::*;
;
	// One case: command, operand bytes, result bytes, expected cycles.
	typedef struct {
		mdu_cmd_t c;
		logic [47:0] o;
		logic [47:0] r;
		int n;
	} mdu_row_t;
	logic CLK, RST_N, WR_EN, START, BUSY, DONE;
	logic [2:0] ADDR;
	logic [7:0] WDATA, RDATA, rb;
	mdu_cmd_t CMD;
	logic [47:0] got;
	int failures, num_checks, cyc, n;
	mdu_row_t rows[12] = '{
		'{'{MDU_OP_MUL16,1'b0,5'h00,1'b0,1'b0},48'h0010_0000_1234,48'h0000_0001_2340,16},
		'{'{MDU_OP_MUL16,1'b1,5'h00,1'b0,1'b0},48'h0003_0000_FFFE,48'h0000_FFFF_FFFA,16},
		'{'{MDU_OP_DIV32,1'b0,5'h00,1'b0,1'b0},48'h0003_0001_0000,48'h0001_0000_5555,32},
		'{'{MDU_OP_DIV32,1'b1,5'h00,1'b0,1'b0},48'h0002_FFFF_FFF9,48'hFFFF_FFFF_FFFD,33},
		'{'{MDU_OP_DIV16,1'b0,5'h00,1'b0,1'b0},48'h0007_ABCD_0064,48'h0002_0000_000E,16},
		'{'{MDU_OP_DIV16,1'b1,5'h00,1'b0,1'b0},48'h0007_ABCD_FF9C,48'hFFFE_0000_FFF2,17},
		'{'{MDU_OP_NORM,1'b0,5'h00,1'b0,1'b0},48'h5A5A_00F0_0000,48'h0008_F000_0000,9},
		'{'{MDU_OP_NORM,1'b0,5'h00,1'b0,1'b0},48'h0000_0000_0000,48'h0000_0000_0000,1},
		'{'{MDU_OP_SHIFT,1'b0,5'h04,1'b0,1'b0},48'h0000_1234_5678,48'h0000_2345_6780,5},
		'{'{MDU_OP_SHIFT,1'b0,5'h1F,1'b1,1'b1},48'h0000_8000_0000,48'h0000_FFFF_FFFF,32},
		'{'{MDU_OP_SHIFT,1'b0,5'h01,1'b1,1'b0},48'h0000_8000_0002,48'h0000_4000_0001,2},
		'{'{MDU_OP_DIV16,1'b1,5'h00,1'b0,1'b0},48'hFFF9_0000_0064,48'h0002_0000_FFF2,17}
	};
	mdu_top u_mdu_top (.CLK, .RST_N, .ADDR, .WR_EN, .WDATA, .RDATA, .START, .CMD, .BUSY, .DONE);
	mdu_core_model u_mdu_core_model (.CLK, .RDATA, .DONE, .ADDR, .WR_EN, .WDATA, .START, .CMD);
	// Compare and count; unknowns never match.
	task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Read all six result bytes, lowest first.
	task automatic rd_all();
		for (int k = 0; k < 6; k++)
			u_mdu_core_model.rd(3'(k), got[8*k +: 8]);
	endtask
	// Verdict and end of run.
	task automatic end_of_test();
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// 100 MHz clock.
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// A hang is cut short well above the expected run length.
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			end_of_test();
		end
	end
	// Table cases, then reset, unmapped and refused-start cases.
	initial begin
		RST_N = 1'b0;
		// Count rising edges; the first step of the clock from unknown to low is a falling edge.
		repeat (2) @(posedge CLK);
		@(negedge CLK);
		RST_N = 1'b1;
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 6; k++)
				u_mdu_core_model.wr(3'(k), rows[i].o[8*k +: 8]);
			u_mdu_core_model.go(rows[i].c, n);
			check("cycles", 48'(n), 48'(rows[i].n));
			rd_all();
			check("result", got, rows[i].r);
			check("status", 48'({BUSY, DONE}), 48'h1);
		end
		u_mdu_core_model.pulse(rows[2].c);
		RST_N = 1'b0;
		repeat (2) @(negedge CLK);
		RST_N = 1'b1;
		check("reset status", 48'({BUSY, DONE}), 48'h0);
		rd_all();
		check("reset bytes", got, 48'h0);
		u_mdu_core_model.wr(3'h6, 8'hAA);
		u_mdu_core_model.rd(3'h7, rb);
		check("unmapped", 48'(rb), 48'h0);
		u_mdu_core_model.wr(3'h0, 8'hFF);
		u_mdu_core_model.wr(3'h4, 8'h01);
		u_mdu_core_model.wr(3'h5, 8'h01);
		u_mdu_core_model.pulse(rows[0].c);
		u_mdu_core_model.go(rows[9].c, n);
		check("refused start", 48'(n), 48'd14);
		rd_all();
		check("product", got, 48'h0000_0000_FFFF);
		end_of_test();
	end
endmodule // mdu_top_bench
